// file: logic/ddc_output_and_nco_frequency_config.sv
// ddc_output_and_nco_frequency_config: per-channel output format, source mux and oscillator
// words; assumes register writes/reads arrive on the sample clock from the serial control port
// Functional notes
// - bit set: complex output becomes real stream at twice output rate
// - bit set: down-converter takes samples from the alternate channel converter
// - each oscillator word is 16 bits, one count is fs over 2^16
// - first band-1 word: low byte 007h, high byte 008h
// - second band-1 word: low byte 009h, high byte 00Ah
// - third band-1 word: low byte 00Bh, high byte 00Ch
// - band-2 word at 00Dh/00Eh, effective only in dual-band mode
// - band-mode bit at 002h: 0 single band, 1 dual band
// - choice codes 00, 01, 10 pick band-1 oscillator one, two, three
`timescale 1ns/10ps
`default_nettype none
module ddc_output_and_nco_frequency_config
    import ddc_cfg_pkg::*;
#(
    parameter int SAMPLE_W = 14
)(
    input  wire logic                           core_clk,
    input  wire logic                           srst,
    input  wire logic                           clk_en,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    input  wire logic [ddc_cfg_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [ddc_cfg_pkg::DATA_W-1:0] reg_wdata,
    output logic      [ddc_cfg_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic [SAMPLE_W-1:0]            own_sample,
    input  wire logic [SAMPLE_W-1:0]            alt_sample,
    output logic      [SAMPLE_W-1:0]            ddc_sample,
    output logic                                real_output_mode,
    output logic                                dual_band_mode,
    output logic      [ddc_cfg_pkg::WORD_W-1:0] band1_word,
    output logic      [ddc_cfg_pkg::WORD_W-1:0] band2_word
);
    import ddc_cfg_pkg::*;

    logic             band_mode;
    logic             out_format;
    logic             alternate_source_select;
    logic [SEL_W-1:0] oscillator_choice;
    logic [WORD_W-1:0] osc_word [0:3];
    logic             next_band_mode;
    logic             next_out_format;
    logic             next_alt_sel;
    logic [SEL_W-1:0] next_choice;
    logic [WORD_W-1:0] next_osc_word [0:3];
    logic [DATA_W-1:0] next_rdata;
    logic [SAMPLE_W-1:0] next_sample;
    logic [WORD_W-1:0] next_band1;
    logic [WORD_W-1:0] next_band2;

    // byte write into one half of a 16-bit word
    function automatic logic [WORD_W-1:0] put_byte(input logic [WORD_W-1:0] w,
                                                   input logic hi,
                                                   input logic [DATA_W-1:0] b);
        put_byte = hi ? {b, w[DATA_W-1:0]} : {w[WORD_W-1:DATA_W], b};
    endfunction

    // register writes; single-bit fields keep bit 0 only, the rest is dropped
    always_comb
    begin
        next_band_mode  = band_mode;
        next_out_format = out_format;
        next_alt_sel    = alternate_source_select;
        next_choice     = oscillator_choice;
        for (int i = 0; i < 4; i++)
        begin
            next_osc_word[i] = osc_word[i];
        end
        if (reg_wr)
        begin
            case (reg_addr)
                OFF_BAND_MODE:  next_band_mode  = reg_wdata[FIELD_BIT0];
                OFF_OUT_FORMAT: next_out_format = reg_wdata[FIELD_BIT0];
                OFF_SRC_SELECT: next_alt_sel    = reg_wdata[FIELD_BIT0];
                OFF_OSC_CHOICE: next_choice     = reg_wdata[SEL_W-1:0];
                OFF_OSC1_LOW:   next_osc_word[0] = put_byte(osc_word[0], 1'b0, reg_wdata);
                OFF_OSC1_HIGH:  next_osc_word[0] = put_byte(osc_word[0], 1'b1, reg_wdata);
                OFF_OSC2_LOW:   next_osc_word[1] = put_byte(osc_word[1], 1'b0, reg_wdata);
                OFF_OSC2_HIGH:  next_osc_word[1] = put_byte(osc_word[1], 1'b1, reg_wdata);
                OFF_OSC3_LOW:   next_osc_word[2] = put_byte(osc_word[2], 1'b0, reg_wdata);
                OFF_OSC3_HIGH:  next_osc_word[2] = put_byte(osc_word[2], 1'b1, reg_wdata);
                OFF_BAND2_LOW:  next_osc_word[3] = put_byte(osc_word[3], 1'b0, reg_wdata);
                OFF_BAND2_HIGH: next_osc_word[3] = put_byte(osc_word[3], 1'b1, reg_wdata);
                default:        next_band_mode  = band_mode;
            endcase
        end
    end

    // read mux; unused upper bits and unmapped offsets read zero
    always_comb
    begin
        next_rdata = reg_rdata;
        if (reg_rd)
        begin
            case (reg_addr)
                OFF_BAND_MODE:  next_rdata = {7'h00, band_mode};
                OFF_OUT_FORMAT: next_rdata = {7'h00, out_format};
                OFF_SRC_SELECT: next_rdata = {7'h00, alternate_source_select};
                OFF_OSC_CHOICE: next_rdata = {6'h00, oscillator_choice};
                OFF_OSC1_LOW:   next_rdata = osc_word[0][DATA_W-1:0];
                OFF_OSC1_HIGH:  next_rdata = osc_word[0][WORD_W-1:DATA_W];
                OFF_OSC2_LOW:   next_rdata = osc_word[1][DATA_W-1:0];
                OFF_OSC2_HIGH:  next_rdata = osc_word[1][WORD_W-1:DATA_W];
                OFF_OSC3_LOW:   next_rdata = osc_word[2][DATA_W-1:0];
                OFF_OSC3_HIGH:  next_rdata = osc_word[2][WORD_W-1:DATA_W];
                OFF_BAND2_LOW:  next_rdata = osc_word[3][DATA_W-1:0];
                OFF_BAND2_HIGH: next_rdata = osc_word[3][WORD_W-1:DATA_W];
                default:        next_rdata = RESET_BYTE;
            endcase
        end
    end

    // datapath outputs, registered so the words change only on clean edges
    always_comb
    begin
        next_sample = alternate_source_select ? alt_sample : own_sample;
        // band-1 oscillator pick; code 11 is unused and holds oscillator one
        case (oscillator_choice)
            CHOICE_OSC1: next_band1 = osc_word[0];
            CHOICE_OSC2: next_band1 = osc_word[1];
            CHOICE_OSC3: next_band1 = osc_word[2];
            default:     next_band1 = osc_word[0];
        endcase
        // band-2 word gated by dual band
        next_band2 = band_mode ? osc_word[3] : '0;
    end

    // state registers; clk_en low freezes everything, srst still clears
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            band_mode               <= 1'b0;
            out_format              <= 1'b0;
            alternate_source_select <= 1'b0;
            oscillator_choice       <= CHOICE_OSC1;
            for (int i = 0; i < 4; i++)
            begin
                osc_word[i] <= {RESET_BYTE, RESET_BYTE};
            end
            reg_rdata        <= RESET_BYTE;
            ddc_sample       <= '0;
            band1_word       <= '0;
            band2_word       <= '0;
            real_output_mode <= 1'b0;
            dual_band_mode   <= 1'b0;
        end
        else if (clk_en)
        begin
            band_mode               <= next_band_mode;
            out_format              <= next_out_format;
            alternate_source_select <= next_alt_sel;
            oscillator_choice       <= next_choice;
            for (int i = 0; i < 4; i++)
            begin
                osc_word[i] <= next_osc_word[i];
            end
            reg_rdata        <= next_rdata;
            ddc_sample       <= next_sample;
            band1_word       <= next_band1;
            band2_word       <= next_band2;
            real_output_mode <= out_format;
            dual_band_mode   <= band_mode;
        end
    end

    property p_src_mux;
        @(posedge core_clk) disable iff (srst)
        (clk_en && $past(clk_en) && !$past(srst)) |-> ddc_sample ==
            ($past(alternate_source_select) ? $past(alt_sample) : $past(own_sample));
    endproperty
    a_src_mux: assert property (p_src_mux) else $error("source mux wrong");

    property p_band2_gate;
        @(posedge core_clk) disable iff (srst)
        (!dual_band_mode && !band_mode) |-> band2_word == '0;
    endproperty
    a_band2_gate: assert property (p_band2_gate) else $error("band2 word leaks");

    property p_osc1_low;
        @(posedge core_clk) disable iff (srst)
        (clk_en && reg_wr && reg_addr == OFF_OSC1_LOW) |=> osc_word[0][7:0] == $past(reg_wdata);
    endproperty
    a_osc1_low: assert property (p_osc1_low) else $error("osc1 low lost");

    property p_osc2_high;
        @(posedge core_clk) disable iff (srst)
        (clk_en && reg_wr && reg_addr == OFF_OSC2_HIGH) |=> osc_word[1][15:8] == $past(reg_wdata);
    endproperty
    a_osc2_high: assert property (p_osc2_high) else $error("osc2 high lost");

    property p_osc3_read;
        @(posedge core_clk) disable iff (srst)
        (clk_en && reg_rd && reg_addr == OFF_OSC3_HIGH) |=> reg_rdata == $past(osc_word[2][15:8]);
    endproperty
    a_osc3_read: assert property (p_osc3_read) else $error("osc3 readback wrong");

    property p_choice;
        @(posedge core_clk) disable iff (srst)
        (clk_en && oscillator_choice == CHOICE_OSC3) |=> band1_word == $past(osc_word[2]);
    endproperty
    a_choice: assert property (p_choice) else $error("oscillator pick wrong");

    property p_format;
        @(posedge core_clk) disable iff (srst)
        (clk_en && reg_wr && reg_addr == OFF_OUT_FORMAT) ##1 clk_en |=> real_output_mode == $past(reg_wdata[0], 2);
    endproperty
    a_format: assert property (p_format) else $error("format flag wrong");

    property p_upper_zero;
        @(posedge core_clk) disable iff (srst)
        (clk_en && reg_rd && reg_addr == OFF_SRC_SELECT) |=> reg_rdata[7:1] == 7'h00;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits nonzero");
endmodule
`default_nettype wire

// file: common/ddc_cfg_pkg.sv
// ddc_cfg_pkg: offsets, resets and widths of the down-converter configuration registers
// assumes an 8-bit register port with byte-wide offsets inside the filter page
`default_nettype none
package ddc_cfg_pkg;
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 8;
    localparam int          WORD_W          = 16;
    localparam int          SEL_W           = 2;
    localparam logic [11:0] OFF_BAND_MODE   = 12'h002;
    localparam logic [11:0] OFF_OUT_FORMAT  = 12'h005;
    localparam logic [11:0] OFF_SRC_SELECT  = 12'h006;
    localparam logic [11:0] OFF_OSC1_LOW    = 12'h007;
    localparam logic [11:0] OFF_OSC1_HIGH   = 12'h008;
    localparam logic [11:0] OFF_OSC2_LOW    = 12'h009;
    localparam logic [11:0] OFF_OSC2_HIGH   = 12'h00A;
    localparam logic [11:0] OFF_OSC3_LOW    = 12'h00B;
    localparam logic [11:0] OFF_OSC3_HIGH   = 12'h00C;
    localparam logic [11:0] OFF_BAND2_LOW   = 12'h00D;
    localparam logic [11:0] OFF_BAND2_HIGH  = 12'h00E;
    localparam logic [11:0] OFF_OSC_CHOICE  = 12'h010;
    localparam logic [7:0]  RESET_BYTE      = 8'h00;
    localparam int          FIELD_BIT0      = 0;
    localparam logic [1:0]  CHOICE_OSC1     = 2'h0;
    localparam logic [1:0]  CHOICE_OSC2     = 2'h1;
    localparam logic [1:0]  CHOICE_OSC3     = 2'h2;
endpackage
`default_nettype wire

// file: sim/test_ddc_output_and_nco_frequency_config.sv
// test_ddc_output_and_nco_frequency_config: self-checking bench for the filter-page registers
// assumes the design samples on the rising core_clk edge; the bench drives on the falling edge
`timescale 1ns/10ps
`default_nettype none
module test_ddc_output_and_nco_frequency_config;
    import ddc_cfg_pkg::*;
    localparam int SW = 14;
    logic              core_clk;
    logic              srst;
    logic              clk_en;
    logic              reg_wr;
    logic              reg_rd;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic [DATA_W-1:0] reg_rdata;
    logic [SW-1:0]     own_sample;
    logic [SW-1:0]     alt_sample;
    logic [SW-1:0]     ddc_sample;
    logic              real_output_mode;
    logic              dual_band_mode;
    logic [WORD_W-1:0] band1_word;
    logic [WORD_W-1:0] band2_word;
    int                num_errors;
    int                n_tests;
    logic [15:0]       osc_val [3];

    ddc_output_and_nco_frequency_config #(.SAMPLE_W(SW)) u_dut (
        .core_clk(core_clk), .srst(srst), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .own_sample(own_sample), .alt_sample(alt_sample), .ddc_sample(ddc_sample),
        .real_output_mode(real_output_mode), .dual_band_mode(dual_band_mode),
        .band1_word(band1_word), .band2_word(band2_word));

    // free-running sample clock, 10 ns period
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // widest result shape; unknown bits never match thanks to case equality
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e, input string w);
        cmp({8'h00, g}, {8'h00, e}, w);
    endtask
    task automatic chk_word(input logic [15:0] g, input logic [15:0] e, input string w);
        cmp(g, e, w);
    endtask
    task automatic chk_flag(input logic g, input logic e, input string w);
        cmp({15'h0000, g}, {15'h0000, e}, w);
    endtask

    // strobe stays up so consecutive calls give back-to-back writes
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge core_clk);
    endtask
    task automatic idle(input int n);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (n) @(negedge core_clk);
    endtask
    // read data is looked at one and a half cycles after the taking edge
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge core_clk);
        reg_rd = 1'b0;
        @(negedge core_clk);
        chk_byte(reg_rdata, e, "read data");
    endtask

    // hang guard, far beyond the about 112 cycles the tests need
    initial
    begin
        #50000;
        num_errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        print_verdict();
    end

    initial
    begin
        {srst, clk_en, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        own_sample = 14'h1A5C;
        alt_sample = 14'h2B3D;
        osc_val = '{16'hA1B2, 16'hC3D4, 16'hE5F6};
        num_errors = 0;
        n_tests = 0;
        srst = 1'b1;
        clk_en = 1'b1;
        repeat (2) @(negedge core_clk);
        srst = 1'b0;
        for (int a = 0; a <= 16; a++)
            rd_chk(a[11:0], RESET_BYTE);
        chk_word(band1_word, 16'h0000, "band1 after reset");
        $display("test reset values done");
        // unused upper bits are written as zero
        wr(OFF_OUT_FORMAT, 8'h01);
        wr(OFF_SRC_SELECT, 8'h01);
        idle(3);
        chk_flag(real_output_mode, 1'b1, "real format");
        chk_word({2'b00, ddc_sample}, {2'b00, alt_sample}, "alternate source");
        rd_chk(OFF_OUT_FORMAT, 8'h01);
        rd_chk(OFF_SRC_SELECT, 8'h01);
        wr(OFF_OUT_FORMAT, 8'h00);
        wr(OFF_SRC_SELECT, 8'h00);
        idle(3);
        chk_flag(real_output_mode, 1'b0, "complex format");
        chk_word({2'b00, ddc_sample}, {2'b00, own_sample}, "own source");
        // a new sample shows one enabled edge later
        own_sample = 14'h0F0F;
        idle(1);
        chk_word({2'b00, ddc_sample}, 16'h0F0F, "own source follows");
        $display("test format and source done");
        for (int k = 0; k < 3; k++)
        begin
            wr(OFF_OSC1_LOW + 12'(2 * k), osc_val[k][7:0]);
            wr(OFF_OSC1_HIGH + 12'(2 * k), osc_val[k][15:8]);
        end
        for (int k = 0; k < 6; k++)
            rd_chk(OFF_OSC1_LOW + 12'(k), osc_val[k / 2][8 * (k % 2) +: 8]);
        for (int c = 3; c >= 0; c--)
        begin
            wr(OFF_OSC_CHOICE, 8'(c));
            idle(3);
            chk_word(band1_word, osc_val[c % 3], "band1 word");
        end
        $display("test oscillator words done");
        wr(OFF_BAND2_LOW, 8'h5A);
        wr(OFF_BAND2_HIGH, 8'h7C);
        idle(3);
        chk_flag(dual_band_mode, 1'b0, "single band");
        chk_word(band2_word, 16'h0000, "band2 in single band");
        wr(OFF_BAND_MODE, 8'h01);
        idle(3);
        chk_flag(dual_band_mode, 1'b1, "dual band");
        chk_word(band2_word, 16'h7C5A, "band2 in dual band");
        rd_chk(OFF_BAND2_HIGH, 8'h7C);
        wr(OFF_BAND_MODE, 8'h00);
        idle(3);
        chk_word(band2_word, 16'h0000, "band2 back to single");
        $display("test band two done");
        wr(12'h003, 8'hAB);
        wr(12'h0FF, 8'hCD);
        rd_chk(12'h003, 8'h00);
        clk_en = 1'b0;
        wr(OFF_OSC1_LOW, 8'h00);
        idle(1);
        clk_en = 1'b1;
        rd_chk(OFF_OSC1_LOW, osc_val[0][7:0]);
        srst = 1'b1;
        idle(1);
        srst = 1'b0;
        idle(1);
        chk_word(band1_word, 16'h0000, "band1 after second reset");
        rd_chk(OFF_OSC1_HIGH, 8'h00);
        $display("test refusals and reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
